// ==== sfla_align.sv ====
// SYSREF gating, edge detection and frame, multiframe and divider phase alignment
`timescale 1ns/10ps
module sfla_align
    import sfla_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // SYSREF pin and control
    input wire logic sysref_pin,
    input wire logic detect_en,
    input wire logic [SFLA_CM_W-1:0] cm_shift_sel,
    // Link configuration
    input wire logic [SFLA_FRAME_W-1:0] frame_len_m1,
    input wire logic [SFLA_K_W-1:0] k_m1,
    input wire logic div_en,
    input wire logic [SFLA_DIV_W-1:0] div_m1,
    // Status outputs
    output logic [SFLA_FRAME_W-1:0] frame_phase,
    output logic [SFLA_K_W-1:0] lmfc_phase,
    output logic [SFLA_DIV_W-1:0] div_phase,
    output logic frame_tick,
    output logic lmfc_tick,
    output logic link_drop,
    output logic aligned,
    output logic realign_pulse,
    output logic [SFLA_CM_W-1:0] cm_shift_cfg
);
    logic sr_meta_r, sr_sync_r, gated_prev_r;
    logic gated;
    logic edge_det;
    logic phase_ok;
    logic [SFLA_FRAME_W-1:0] frame_r;
    logic [SFLA_K_W-1:0] lmfc_r;
    logic [SFLA_DIV_W-1:0] div_r;
    logic frame_wrap, lmfc_wrap;

    // Two-stage synchroniser for the pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sr_meta_r <= 1'b0;
            sr_sync_r <= 1'b0;
        end else begin
            sr_meta_r <= sysref_pin;
            sr_sync_r <= sr_meta_r;
        end
    end

    assign gated = sr_sync_r & detect_en;

    // Previous gated sample; high at enable shows as edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gated_prev_r <= 1'b0;
        end else begin
            gated_prev_r <= gated;
        end
    end
    assign edge_det = gated & ~gated_prev_r;

    // Expected phase at an edge, once aligned: frame and multiframe counters at zero, divider too when enabled
    assign phase_ok = aligned && (frame_r == SFLA_FRAME_RST) && (lmfc_r == SFLA_LMFC_RST)
                      && (!div_en || div_r == SFLA_DIV_RST);
    assign frame_wrap = (frame_r == frame_len_m1);
    assign lmfc_wrap = frame_wrap && (lmfc_r == k_m1);

    // Frame and multiframe counters; default phase at reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_r <= SFLA_FRAME_RST;
            lmfc_r <= SFLA_LMFC_RST;
        end else if (edge_det && !phase_ok) begin
            // Re-phase to the edge; a one-clock frame wraps at once
            frame_r <= (frame_len_m1 == SFLA_FRAME_RST) ? SFLA_FRAME_RST : SFLA_FRAME_RST + 4'h1;
            // One-clock frames have already left multiframe slot zero when the multiframe holds more than one frame
            lmfc_r <= (frame_len_m1 == SFLA_FRAME_RST && k_m1 != SFLA_LMFC_RST) ? SFLA_LMFC_RST + 6'h01
                                                                                : SFLA_LMFC_RST;
        end else begin
            frame_r <= frame_wrap ? SFLA_FRAME_RST : frame_r + 4'h1;
            if (frame_wrap) begin
                lmfc_r <= lmfc_wrap ? SFLA_LMFC_RST : lmfc_r + 6'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= SFLA_DIV_RST;
        end else if (div_en && edge_det && !phase_ok) begin
            // Divide by one has a single phase, so stay at zero
            div_r <= (div_m1 == SFLA_DIV_RST) ? SFLA_DIV_RST : SFLA_DIV_RST + 2'h1;
        end else if (div_en) begin
            div_r <= (div_r == div_m1) ? SFLA_DIV_RST : div_r + 2'h1;
        end else begin
            div_r <= SFLA_DIV_RST;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aligned <= 1'b0;
            link_drop <= 1'b0;
            realign_pulse <= 1'b0;
        end else begin
            realign_pulse <= edge_det && !phase_ok;
            link_drop <= edge_det && !phase_ok;
            if (edge_det) begin
                aligned <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cm_shift_cfg <= SFLA_CM_RST;
        end else begin
            cm_shift_cfg <= cm_shift_sel;
        end
    end

    // Phase outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_phase <= SFLA_FRAME_RST;
            lmfc_phase <= SFLA_LMFC_RST;
            div_phase <= SFLA_DIV_RST;
            frame_tick <= 1'b0;
            lmfc_tick <= 1'b0;
        end else begin
            frame_phase <= frame_r;
            lmfc_phase <= lmfc_r;
            div_phase <= div_r;
            frame_tick <= (frame_r == SFLA_FRAME_RST);
            lmfc_tick <= (frame_r == SFLA_FRAME_RST) && (lmfc_r == SFLA_LMFC_RST);
        end
    end

    a_gate_blocks: assert property (@(posedge clk) disable iff (rst)
        !detect_en |=> !realign_pulse) else $error("Realign while gate closed");
    a_edge_detect: assert property (@(posedge clk) disable iff (rst)
        (gated && !$past(gated)) |-> edge_det) else $error("Edge missed");
    a_rephase_cnt: assert property (@(posedge clk) disable iff (rst)
        (edge_det && !phase_ok && frame_len_m1 != 4'h0) |=> (frame_r == 4'h1 && lmfc_r == 6'h00))
        else $error("No re-phase");
    a_keep_link: assert property (@(posedge clk) disable iff (rst)
        (edge_det && phase_ok) |=> !link_drop) else $error("Link dropped on match");
    a_drop_pair: assert property (@(posedge clk) disable iff (rst)
        link_drop |-> realign_pulse) else $error("Drop without realign");
    a_edge_aligns: assert property (@(posedge clk) disable iff (rst)
        edge_det |=> aligned) else $error("Not aligned after edge");
    a_enable_high: assert property (@(posedge clk) disable iff (rst)
        (!aligned && $rose(detect_en) && sr_sync_r) |=> realign_pulse) else $error("Enable-high missed");
    a_div_phase: assert property (@(posedge clk) disable iff (rst)
        (div_en && edge_det && !phase_ok && div_m1 != 2'h0) |=> div_r == 2'h1) else $error("Divider not re-phased");

    // Steps of a re-alignment: request at the edge, then drop and pulse together; also an edge that agrees
    sequence s_rephase_req;
        edge_det && !phase_ok;
    endsequence
    sequence s_rephase_done;
        realign_pulse && link_drop;
    endsequence
    sequence s_phase_match;
        edge_det && phase_ok;
    endsequence

    // Drop and realign follow a mismatch
    a_rephase_seq: assert property (@(posedge clk) disable iff (rst)
        s_rephase_req |=> s_rephase_done) else $error("Re-phase steps missing");

    a_match_quiet: assert property (@(posedge clk) disable iff (rst)
        s_phase_match |=> !realign_pulse) else $error("Realign on agreeing edge");

    a_no_spurious: assert property (@(posedge clk) disable iff (rst)
        !edge_det |=> !realign_pulse) else $error("Realign without edge");

    a_first_edge: assert property (@(posedge clk) disable iff (rst)
        (edge_det && !aligned) |=> realign_pulse) else $error("First edge ignored");

    a_gate_no_edge: assert property (@(posedge clk) disable iff (rst)
        !detect_en |-> !edge_det) else $error("Edge while gate closed");

    a_aligned_hold: assert property (@(posedge clk) disable iff (rst)
        aligned |=> aligned) else $error("Alignment lost");

    a_frame_step: assert property (@(posedge clk) disable iff (rst)
        (!edge_det && !frame_wrap) |=> frame_r == $past(frame_r) + 4'h1) else $error("Frame counter stalled");

    // Frame counter wraps at frame end
    a_frame_wrap: assert property (@(posedge clk) disable iff (rst)
        (!edge_det && frame_wrap) |=> frame_r == 4'h0) else $error("Frame counter missed wrap");

    // Divide by one stays at phase zero
    a_div_unity: assert property (@(posedge clk) disable iff (rst)
        (div_en && div_m1 == 2'h0) |=> div_r == 2'h0) else $error("Divider left phase zero");

    a_div_off: assert property (@(posedge clk) disable iff (rst)
        !div_en |=> div_r == 2'h0) else $error("Divider running while off");

    // Level shift setting follows its select
    a_cm_follow: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> cm_shift_cfg == $past(cm_shift_sel)) else $error("Level shift setting stale");

    a_prev_sample: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> gated_prev_r == $past(gated)) else $error("Previous sample wrong");

endmodule : sfla_align

// ==== sfla_pkg.sv ====
// Constants for the SYSREF frame and multiframe clock alignment block
package sfla_pkg;
    localparam int SFLA_FRAME_W = 4;
    localparam int SFLA_K_W = 6;
    localparam int SFLA_DIV_W = 2;
    localparam int SFLA_CM_W = 3;
    localparam logic [SFLA_FRAME_W-1:0] SFLA_FRAME_RST = 4'h0;
    localparam logic [SFLA_K_W-1:0] SFLA_LMFC_RST = 6'h00;
    localparam logic [SFLA_DIV_W-1:0] SFLA_DIV_RST = 2'h0;
    localparam logic [SFLA_CM_W-1:0] SFLA_CM_RST = 3'h0;
endpackage : sfla_pkg

// ==== sfla_sysref_src.sv ====
// Behavioural clock generator side that sends SYSREF bursts
`timescale 1ns/10ps
module sfla_sysref_src (
    // Clock
    input wire logic clk,
    // Burst request
    input wire logic go,
    input wire logic [15:0] hi_len,
    input wire logic [15:0] period,
    input wire logic [7:0] count,
    // SYSREF pin and status
    output logic sysref_pin,
    output logic busy
);
    initial begin
        sysref_pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                repeat (count) begin
                    sysref_pin <= 1'b1;
                    repeat (hi_len) @(posedge clk);
                    sysref_pin <= 1'b0;
                    repeat (period - hi_len) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule : sfla_sysref_src

// ==== sfla_align_tb_top.sv ====
// Self-checking bench for SYSREF frame and multiframe alignment
`timescale 1ns/10ps
module sfla_align_tb_top;
    import sfla_pkg::*;
    typedef struct {int at; int sl;} sfla_note_t;
    logic clk = 1'b0, rst = 1'b1, det = 1'b0, go = 1'b0, div_en = 1'b0, bad = 1'b0, prev = 1'b0;
    logic pin, busy, ld, al, rp, ft, lt;
    logic [1:0] dph;
    int tk = 0;
    logic [2:0] cm = 3'h0, cfg;
    logic [3:0] fl = 4'h1, fph;
    logic [5:0] km = 6'h1, lph;
    logic [1:0] dm = 2'h0;
    logic [15:0] hi = 16'h4, per = 16'h8;
    logic [7:0] cnt = 8'h1;
    int cyc = 0, n_rise = 0, fail_count = 0, check_count = 0, fk;
    sfla_note_t q[$];
    sfla_note_t n;
    sfla_align dut (.clk(clk), .rst(rst), .sysref_pin(pin), .detect_en(det), .cm_shift_sel(cm), .frame_len_m1(fl),
        .k_m1(km), .div_en(div_en), .div_m1(dm), .frame_phase(fph), .lmfc_phase(lph), .div_phase(dph),
        .frame_tick(ft), .lmfc_tick(lt), .link_drop(ld), .aligned(al), .realign_pulse(rp), .cm_shift_cfg(cfg));
    sfla_sysref_src src (.clk(clk), .go(go), .hi_len(hi), .period(per), .count(cnt), .sysref_pin(pin), .busy(busy));
    // Clock, 8 ns period
    initial forever #4 clk = ~clk;
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task chk_cyc(input sfla_note_t e, input int g);
        check_count++;
        if (g < e.at || g > e.at + e.sl) begin
            fail_count++;
            $display("unexpected realign_pulse cycle expected %0d seen %0d", e.at, g);
        end
    endtask : chk_cyc
    task conclude;
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    // Cycle count and notes for the first gated pin rise of a run, or for every one when bad is set
    always @(posedge clk) begin
        cyc <= cyc + 1;
        prev <= pin;
        if (pin && !prev && det && !rst) begin
            if (n_rise == 0 || bad) q.push_back('{cyc + 2, 0});
            n_rise++;
        end
    end
    // Compare each realign pulse with the oldest note
    always @(negedge clk) begin
        // One frame after a realign the frame boundary shows
        if (tk > 0) begin
            tk--;
            if (tk == 0) begin
                chk("frame_tick", 8'h1, {7'h0, ft});
                chk("lmfc_tick", 8'h0, {7'h0, lt});
                chk("frame_phase", {4'h0, SFLA_FRAME_RST}, {4'h0, fph});
                chk("lmfc_phase", {2'h0, SFLA_LMFC_RST} + 8'h1, {2'h0, lph});
                chk("div_phase", div_en ? 8'((fl + 1) % (dm + 1)) : 8'h0, {6'h0, dph});
            end
        end
        if (rp === 1'b1) begin
            tk = fl + 1;
            if (q.size() == 0) chk("realign_pulse", 8'h0, 8'h1);
            else begin
                n = q.pop_front();
                chk_cyc(n, cyc - 1);
            end
            chk("link_drop", 8'h1, {7'h0, ld});
            chk("aligned", 8'h1, {7'h0, al});
        end
    end
    // One reset, burst and drain
    task run(input logic en, input int c, input int p, input logic b, input logic late);
        int i;
        rst <= 1'b1;
        det <= 1'b0;
        repeat (12) @(posedge clk);
        chk("aligned", 8'h0, {7'h0, al});
        chk("frame_phase", {4'h0, SFLA_FRAME_RST}, {4'h0, fph});
        chk("lmfc_phase", {2'h0, SFLA_LMFC_RST}, {2'h0, lph});
        rst <= 1'b0;
        det <= en;
        bad <= b;
        n_rise = 0;
        cnt <= c[7:0];
        per <= p[15:0];
        hi <= 16'(2 * (fl + 1));
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
        if (late) begin
            det <= 1'b1;
            q.push_back('{cyc + 1, 1});
        end
        for (i = 0; i < 9000 && busy !== 1'b0; i++) @(posedge clk);
        if (i == 9000) begin
            fail_count++;
            conclude();
        end
        repeat (8) @(posedge clk);
        chk("pending", 8'h0, 8'(q.size()));
        q.delete();
        chk("cm_shift_cfg", {5'h0, cm}, {5'h0, cfg});
    endtask : run
    // Main sequence over random frame and multiframe sizes
    initial begin
        int j, m;
        void'($urandom(32'hbee2d7d4));
        for (j = 0; j < 3; j++) begin
            fl <= 4'(1 + $urandom % 3);
            km <= 6'(1 + $urandom % 7);
            cm <= 3'($urandom);
            div_en <= 1'($urandom);
            dm <= 2'($urandom);
            m = 2 + $urandom % 2;
            @(posedge clk);
            // A period that also keeps the divided clock in phase
            fk = (fl + 1) * (km + 1) * (div_en ? dm + 1 : 1);
            run(1'b0, 1, m * fk, 1'b0, 1'b0);
            run(1'b1, 1, m * fk, 1'b0, 1'b0);
            run(1'b1, 4, m * fk, 1'b0, 1'b0);
            run(1'b1, 3, m * fk + 1, 1'b1, 1'b0);
            run(1'b0, 2, 3 * fk + 3, 1'b0, 1'b1);
        end
        conclude();
    end
endmodule : sfla_align_tb_top
